// *** core/codec_audio_config_agc_regs.sv ***
`timescale 1ns/1ps
module codec_audio_config_agc_regs
  import codec_audio_cfg_pkg::*;
#(
  parameter int MS_CYCLES = LOOP_TICK_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [5:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic headset_selected,
  input wire logic [7:0] level_half_db,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  output logic hpf_enable,
  output logic [1:0] hpf_corner,
  output logic [5:0] word_bits,
  output logic [1:0] data_format,
  output logic [3:0] playback_div_x2,
  output logic [3:0] record_div_x2,
  output logic headset_mute,
  output logic [7:0] headset_gain,
  output logic [7:0] loop_target,
  output logic [8:0] attack_ms,
  output logic [8:0] decay_ms
);

  typedef struct packed {
    logic [1:0] adc_highpass_select;
    logic [1:0] sample_word_length;
    logic [1:0] audio_data_format;
    logic [2:0] playback_rate_divisor;
    logic [2:0] record_rate_divisor;
    logic headset_input_mute;
    logic [6:0] headset_input_gain;
    logic [2:0] headset_gain_loop_target;
    logic [3:0] headset_gain_loop_time_constant;
    logic headset_gain_loop_enable;
    loop_state_t loop_state;
    logic [7:0] gain;
    logic [15:0] ms_div;
    logic ms_tick;
    logic [8:0] step_cnt;
    logic [15:0] rdata;
    logic rvalid;
    logic hpf_on;
    logic [5:0] bits;
    logic [1:0] fmt;
    logic [3:0] dac_x2;
    logic [3:0] adc_x2;
    logic mute_out;
    logic [7:0] gain_out;
    logic [7:0] target;
    logic [8:0] attack;
    logic [8:0] decay;
  } state_t;

  state_t s;
  state_t next_s;

  function automatic logic [15:0] format_word(input state_t st);
    logic [15:0] w;
    w = 16'h0000;
    w[HPF_POS +: 2] = st.adc_highpass_select;
    w[SAMPLE_WORD_LENGTH_POS +: 2] = st.sample_word_length;
    w[FMT_POS +: 2] = st.audio_data_format;
    w[DAC_POS +: 3] = st.playback_rate_divisor;
    w[ADC_POS +: 3] = st.record_rate_divisor;
    return w;
  endfunction : format_word

  always_comb begin
    next_s = s;
    next_s.rvalid = 1'b0;
    if (s.ms_div == 16'(MS_CYCLES - 1)) begin
      next_s.ms_div = 16'h0000;
      next_s.ms_tick = 1'b1;
    end else begin
      next_s.ms_div = s.ms_div + 16'h0001;
      next_s.ms_tick = 1'b0;
    end
    if (reg_wr) begin
      case (reg_addr)
        ADDR_FORMAT_RATE: begin
          next_s.adc_highpass_select = reg_wdata[HPF_POS +: 2];
          next_s.sample_word_length = reg_wdata[SAMPLE_WORD_LENGTH_POS +: 2];
          next_s.audio_data_format = reg_wdata[FMT_POS +: 2];
          next_s.playback_rate_divisor = reg_wdata[DAC_POS +: 3];
          next_s.record_rate_divisor = reg_wdata[ADC_POS +: 3];
        end
        ADDR_HEADSET_GAIN: begin
          next_s.headset_input_mute = reg_wdata[MUTE_POS];
          next_s.headset_input_gain = reg_wdata[PGA_POS +: 7];
          next_s.headset_gain_loop_target = reg_wdata[TGT_POS +: 3];
          next_s.headset_gain_loop_time_constant = reg_wdata[TC_POS +: 4];
          next_s.headset_gain_loop_enable = reg_wdata[EN_POS];
        end
        default: begin
        end
      endcase
    end
    if (reg_rd) begin
      next_s.rvalid = 1'b1;
      case (reg_addr)
        ADDR_FORMAT_RATE: next_s.rdata = format_word(s);
        ADDR_HEADSET_GAIN: begin
          next_s.rdata = {s.headset_input_mute, s.headset_input_gain, s.headset_gain_loop_target,
                          s.headset_gain_loop_time_constant, s.headset_gain_loop_enable};
          if (s.headset_gain_loop_enable && headset_selected) begin
            next_s.rdata[PGA_POS +: 8] = s.gain;
          end
        end
        default: next_s.rdata = 16'h0000;
      endcase
    end
    // loop owns gain only when enabled
    case (s.loop_state)
      LOOP_OFF: begin
        next_s.gain = {1'b0, s.headset_input_gain};
        next_s.step_cnt = 9'h000;
        if (s.headset_gain_loop_enable) begin
          next_s.loop_state = LOOP_TRACK;
          // loop never starts above +59.5 dB
          if ($signed({1'b0, s.headset_input_gain}) > $signed(GAIN_MAX)) begin
            next_s.gain = GAIN_MAX;
          end
        end
      end
      LOOP_TRACK: begin
        if (!s.headset_gain_loop_enable) begin
          next_s.loop_state = LOOP_OFF;
        end else if (s.ms_tick) begin
          if ($signed(level_half_db) > $signed(s.target)) begin
            if (s.step_cnt + 9'h001 >= s.attack) begin
              next_s.step_cnt = 9'h000;
              if ($signed(s.gain) > $signed(GAIN_MIN)) begin
                next_s.gain = s.gain - 8'h01;
              end
            end else begin
              next_s.step_cnt = s.step_cnt + 9'h001;
            end
          end else if ($signed(level_half_db) < $signed(s.target)) begin
            if (s.step_cnt + 9'h001 >= s.decay) begin
              next_s.step_cnt = 9'h000;
              if ($signed(s.gain) < $signed(GAIN_MAX)) begin
                next_s.gain = s.gain + 8'h01;
              end
            end else begin
              next_s.step_cnt = s.step_cnt + 9'h001;
            end
          end else begin
            next_s.step_cnt = 9'h000;
          end
        end
      end
      default: next_s.loop_state = LOOP_OFF;
    endcase
    next_s.hpf_on = (s.adc_highpass_select != HPF_RST);
    next_s.bits = WORD_BITS[s.sample_word_length];
    next_s.fmt = s.audio_data_format;
    next_s.dac_x2 = DIV_TIMES2[s.playback_rate_divisor];
    next_s.adc_x2 = DIV_TIMES2[s.record_rate_divisor];
    next_s.mute_out = s.headset_input_mute && !s.headset_gain_loop_enable;
    // gain path from manual or loop
    next_s.gain_out = s.gain;
    next_s.target = TARGET_HALF_DB[s.headset_gain_loop_target];
    next_s.attack = ATTACK_MS[s.headset_gain_loop_time_constant[1:0]];
    next_s.decay = DECAY_MS[s.headset_gain_loop_time_constant[3:2]];
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{adc_highpass_select: HPF_RST, sample_word_length: SAMPLE_WORD_LENGTH_RST, audio_data_format: FMT_RST,
             playback_rate_divisor: RATE_RST, record_rate_divisor: RATE_RST, headset_input_mute: MUTE_RST,
             headset_input_gain: PGA_RST, headset_gain_loop_target: TGT_RST,
             headset_gain_loop_time_constant: TC_RST, headset_gain_loop_enable: EN_RST,
             loop_state: LOOP_OFF, gain: {1'b0, PGA_RST}, ms_div: 16'h0000, ms_tick: 1'b0,
             step_cnt: 9'h000, rdata: 16'h0000, rvalid: 1'b0, hpf_on: 1'b0, bits: WORD_BITS[0],
             fmt: FMT_I2S, dac_x2: DIV_TIMES2[0], adc_x2: DIV_TIMES2[0], mute_out: MUTE_RST,
             gain_out: {1'b0, PGA_RST}, target: TARGET_HALF_DB[0], attack: ATTACK_MS[0],
             decay: DECAY_MS[0]};
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata = s.rdata;
  assign reg_rvalid = s.rvalid;
  assign hpf_enable = s.hpf_on;
  assign hpf_corner = s.adc_highpass_select;
  assign word_bits = s.bits;
  assign data_format = s.fmt;
  assign playback_div_x2 = s.dac_x2;
  assign record_div_x2 = s.adc_x2;
  assign headset_mute = s.mute_out;
  assign headset_gain = s.gain_out;
  assign loop_target = s.target;
  assign attack_ms = s.attack;
  assign decay_ms = s.decay;

  // checks; decodes settle one cycle after the field
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_write_gain_manual;
    reg_wr && reg_addr == ADDR_HEADSET_GAIN && !reg_wdata[EN_POS] && s.loop_state == LOOP_OFF
      && !s.headset_gain_loop_enable;
  endsequence
  sequence s_read_format;
    reg_rd && reg_addr == ADDR_FORMAT_RATE;
  endsequence

  property p_hpf;
    ##1 hpf_enable == ($past(s.adc_highpass_select) != 2'h0);
  endproperty
  a_hpf: assert property (p_hpf) else $error("highpass enable wrong");

  property p_bits;
    ##1 word_bits == WORD_BITS[$past(s.sample_word_length)];
  endproperty
  a_bits: assert property (p_bits) else $error("word length decode wrong");

  property p_fmt;
    ##1 data_format == $past(s.audio_data_format);
  endproperty
  a_fmt: assert property (p_fmt) else $error("format output wrong");

  property p_div;
    ##1 playback_div_x2 == DIV_TIMES2[$past(s.playback_rate_divisor)]
      && record_div_x2 == DIV_TIMES2[$past(s.record_rate_divisor)];
  endproperty
  a_div: assert property (p_div) else $error("rate divisor wrong");

  property p_manual_mute;
    s_write_gain_manual ##2 1'b1 |-> headset_mute == $past(reg_wdata[MUTE_POS], 2);
  endproperty
  a_manual_mute: assert property (p_manual_mute) else $error("manual mute not applied");

  property p_manual_gain;
    s_write_gain_manual ##1 !s.headset_gain_loop_enable ##1 1'b1
      |-> s.gain == {1'b0, $past(reg_wdata[PGA_POS +: 7], 2)};
  endproperty
  a_manual_gain: assert property (p_manual_gain) else $error("manual gain not applied");

  property p_readback;
    reg_rd && reg_addr == ADDR_HEADSET_GAIN && s.headset_gain_loop_enable && headset_selected
      |=> reg_rvalid && reg_rdata[15:8] == $past(s.gain);
  endproperty
  a_readback: assert property (p_readback) else $error("loop gain not read back");

  property p_gain_range;
    s.loop_state == LOOP_TRACK |-> $signed(s.gain) <= $signed(GAIN_MAX) && $signed(s.gain) >= $signed(GAIN_MIN);
  endproperty
  a_gain_range: assert property (p_gain_range) else $error("loop gain out of range");

  property p_step_on_tick;
    s.loop_state == LOOP_TRACK && $past(s.loop_state) == LOOP_TRACK && s.gain != $past(s.gain)
      |-> $past(s.ms_tick);
  endproperty
  a_step_on_tick: assert property (p_step_on_tick) else $error("gain stepped off the tick");

  property p_tick_spacing;
    s.ms_tick |=> !s.ms_tick;
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("tick not a single pulse");

  property p_target;
    ##1 loop_target == TARGET_HALF_DB[$past(s.headset_gain_loop_target)];
  endproperty
  a_target: assert property (p_target) else $error("target decode wrong");

  property p_reserved;
    s_read_format |=> reg_rvalid && reg_rdata[13:12] == 2'h0 && reg_rdata[7:6] == 2'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

endmodule : codec_audio_config_agc_regs

// *** shared/codec_audio_cfg_pkg.sv ***
package codec_audio_cfg_pkg;
  // register indices on the control port
  localparam logic [5:0] ADDR_FORMAT_RATE = 6'h00;
  localparam logic [5:0] ADDR_HEADSET_GAIN = 6'h01;
  // audio_format_rate_control fields
  localparam int HPF_POS = 14;
  localparam int SAMPLE_WORD_LENGTH_POS = 10;
  localparam int FMT_POS = 8;
  localparam int DAC_POS = 3;
  localparam int ADC_POS = 0;
  // headset_input_gain_control fields
  localparam int MUTE_POS = 15;
  localparam int PGA_POS = 8;
  localparam int TGT_POS = 5;
  localparam int TC_POS = 1;
  localparam int EN_POS = 0;
  // reset values
  localparam logic [1:0] HPF_RST = 2'h0;
  localparam logic [1:0] SAMPLE_WORD_LENGTH_RST = 2'h0;
  localparam logic [1:0] FMT_RST = 2'h0;
  localparam logic [2:0] RATE_RST = 3'h0;
  localparam logic MUTE_RST = 1'b1;
  localparam logic [6:0] PGA_RST = 7'h7F;
  localparam logic [2:0] TGT_RST = 3'h0;
  localparam logic [3:0] TC_RST = 4'h0;
  localparam logic EN_RST = 1'b0;
  // data formats
  localparam logic [1:0] FMT_I2S = 2'h0;
  localparam logic [1:0] FMT_DSP = 2'h1;
  localparam logic [1:0] FMT_RIGHT = 2'h2;
  localparam logic [1:0] FMT_LEFT = 2'h3;
  // decode tables, gains in signed half-dB units
  localparam logic [5:0] WORD_BITS [4] = '{6'h10, 6'h14, 6'h18, 6'h20};
  localparam logic [3:0] DIV_TIMES2 [8] = '{4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'hA, 4'hB, 4'hC};
  localparam logic [7:0] TARGET_HALF_DB [8] = '{8'hF5, 8'hF0, 8'hEC, 8'hE8, 8'hE4, 8'hDE, 8'hD8, 8'hD0};
  localparam logic [8:0] ATTACK_MS [4] = '{9'h008, 9'h00B, 9'h010, 9'h014};
  localparam logic [8:0] DECAY_MS [4] = '{9'h064, 9'h0C8, 9'h190, 9'h1F4};
  localparam logic [7:0] GAIN_MAX = 8'h77;
  localparam logic [7:0] GAIN_MIN = 8'hE8;
  // loop timebase, fixed from the system clock
  localparam int CLK_PERIOD_NS = 40;
  localparam int LOOP_TICK_NS = 1000000;
  localparam int LOOP_TICK_CYCLES = LOOP_TICK_NS / CLK_PERIOD_NS;
  typedef enum logic [1:0] {
    LOOP_OFF = 2'b01,
    LOOP_TRACK = 2'b10
  } loop_state_t;
endpackage : codec_audio_cfg_pkg

// *** test/level_source.sv ***
`timescale 1ns/1ps
module level_source (
  input wire logic sys_clk,
  input wire logic want_sel,
  input wire logic [7:0] want_level,
  output logic headset_selected = 1'b0,
  output logic [7:0] level_half_db = 8'h00
);
  // front end settles off the sampling edge, so the loop never sees a race
  always @(negedge sys_clk) begin
    headset_selected <= want_sel;
    level_half_db <= want_level;
  end
endmodule : level_source

// *** test/testbench.sv ***
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; \
  $display("unexpected at %0t: got %0h exp %0h", $time, (a), (e)); end end
module testbench;
  import codec_audio_cfg_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [5:0] reg_addr = 6'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic want_sel = 1'b0;
  logic [7:0] want_level = 8'h00;
  logic headset_selected, reg_rvalid, hpf_enable, headset_mute;
  logic [7:0] level_half_db, headset_gain, loop_target;
  logic [15:0] reg_rdata, d;
  logic [1:0] hpf_corner, data_format, c2;
  logic [5:0] word_bits;
  logic [3:0] playback_div_x2, record_div_x2;
  logic [8:0] attack_ms, decay_ms;
  logic [2:0] c3, a3;
  int n_mismatch = 0;
  int tests_run = 0;
  int cycles = 0;
  // own decode tables, kept apart from the design's
  logic [5:0] wb [4] = '{6'h10, 6'h14, 6'h18, 6'h20};
  logic [3:0] dx2 [8] = '{4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'hA, 4'hB, 4'hC};
  logic [7:0] tg [8] = '{8'hF5, 8'hF0, 8'hEC, 8'hE8, 8'hE4, 8'hDE, 8'hD8, 8'hD0};
  logic [8:0] at [4] = '{9'h008, 9'h00B, 9'h010, 9'h014};
  logic [8:0] dc [4] = '{9'h064, 9'h0C8, 9'h190, 9'h1F4};
  always #20 sys_clk = ~sys_clk;
  level_source front (.sys_clk(sys_clk), .want_sel(want_sel), .want_level(want_level),
    .headset_selected(headset_selected), .level_half_db(level_half_db));
  codec_audio_config_agc_regs #(.MS_CYCLES(10)) DUT (.sys_clk(sys_clk), .rst_n(rst_n),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .headset_selected(headset_selected), .level_half_db(level_half_db),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .hpf_enable(hpf_enable),
    .hpf_corner(hpf_corner), .word_bits(word_bits), .data_format(data_format),
    .playback_div_x2(playback_div_x2), .record_div_x2(record_div_x2),
    .headset_mute(headset_mute), .headset_gain(headset_gain), .loop_target(loop_target),
    .attack_ms(attack_ms), .decay_ms(decay_ms));
  task automatic wr(input logic [5:0] a, input logic [15:0] v);
    @(negedge sys_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = v;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    @(negedge sys_clk);
  endtask : wr
  task automatic rdchk(input logic [5:0] a, input logic [15:0] e);
    @(negedge sys_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    // rvalid stands one cycle only, so look now
    `CHK(reg_rvalid, 1'b1)
    `CHK(reg_rdata, e)
  endtask : rdchk
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish
  // the whole run takes about 6350 cycles, both loop ramps about 4200 of them
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 9000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (5) @(negedge sys_clk);
    rst_n = 1'b1;
    rdchk(ADDR_FORMAT_RATE, 16'h0000);
    rdchk(ADDR_HEADSET_GAIN, 16'hFF00);
    `CHK(word_bits, 6'h10)
    `CHK(playback_div_x2, 4'h2)
    `CHK(headset_mute, 1'b1)
    `CHK(headset_gain, 8'h7F)
    $display("test reset values done");
    wr(ADDR_FORMAT_RATE, 16'hFFFF);
    rdchk(ADDR_FORMAT_RATE, 16'hCF3F);
    wr(6'h02, 16'h1234);
    rdchk(ADDR_FORMAT_RATE, 16'hCF3F);
    rdchk(6'h02, 16'h0000);
    $display("test reserved bits done");
    // reference rate is the host's; only divisor codes reach here
    for (int i = 0; i < 8; i++) begin
      c2 = 2'(i);
      c3 = 3'(i);
      // right-justified only with equal divisors, an integer ratio
      a3 = (c2 == FMT_RIGHT) ? c3 : 3'(7 - i);
      wr(ADDR_FORMAT_RATE, {c2, 2'h0, c2, c2, 2'h0, c3, a3});
      `CHK(hpf_enable, (c2 != 2'h0))
      `CHK(hpf_corner, c2)
      `CHK(word_bits, wb[c2])
      `CHK(data_format, c2)
      `CHK(playback_div_x2, dx2[c3])
      `CHK(record_div_x2, dx2[a3])
    end
    $display("test format and rate codes done");
    for (int j = 0; j < 16; j++) begin
      d = {j[0], 7'(j * 8), 3'(j), 4'(j), 1'b0};
      wr(ADDR_HEADSET_GAIN, d);
      rdchk(ADDR_HEADSET_GAIN, d);
      `CHK(headset_mute, d[15])
      `CHK(headset_gain, {1'b0, d[14:8]})
      `CHK(loop_target, tg[d[7:5]])
      `CHK(attack_ms, at[d[2:1]])
      `CHK(decay_ms, dc[d[4:3]])
    end
    $display("test gain fields done");
    want_sel = 1'b1;
    want_level = 8'h00;
    wr(ADDR_HEADSET_GAIN, 16'h1001);
    `CHK(headset_mute, 1'b0)
    // applied gain reaches the pin one cycle after the loop takes over
    @(negedge sys_clk);
    `CHK(headset_gain, 8'h10)
    rdchk(ADDR_HEADSET_GAIN, 16'h1001);
    repeat (50) @(negedge sys_clk);
    `CHK(headset_gain, 8'h10)
    repeat (50) @(negedge sys_clk);
    `CHK(headset_gain, 8'h0F)
    repeat (4000) @(negedge sys_clk);
    rdchk(ADDR_HEADSET_GAIN, 16'hE801);
    want_sel = 1'b0;
    @(negedge sys_clk);
    rdchk(ADDR_HEADSET_GAIN, 16'h1001);
    wr(ADDR_HEADSET_GAIN, 16'h9000);
    // loop leaves, then the programmed value comes back through the output stage
    repeat (2) @(negedge sys_clk);
    `CHK(headset_gain, 8'h10)
    `CHK(headset_mute, 1'b1)
    // quiet input: decay raises the gain until the upper clamp
    want_level = 8'hC0;
    wr(ADDR_HEADSET_GAIN, 16'h7601);
    repeat (500) @(negedge sys_clk);
    `CHK(headset_gain, 8'h76)
    repeat (600) @(negedge sys_clk);
    `CHK(headset_gain, 8'h77)
    want_sel = 1'b1;
    repeat (1000) @(negedge sys_clk);
    rdchk(ADDR_HEADSET_GAIN, 16'h7701);
    $display("test gain loop done");
    tally_and_finish();
  end
endmodule : testbench
